// file: rtl/dma_channel_pkg.sv
package dma_channel_pkg;

    // Register byte offsets
    localparam logic [4:0] CTRL_OFS = 5'h00;
    localparam logic [4:0] SRC_OFS = 5'h04;
    localparam logic [4:0] DST_OFS = 5'h08;
    localparam logic [4:0] COUNT_OFS = 5'h0C;
    localparam logic [4:0] OFFSET0_OFS = 5'h10;
    localparam logic [4:0] OFFSET1_OFS = 5'h14;
    localparam logic [4:0] STATUS_OFS = 5'h18;
    localparam logic [4:0] MASK_OFS = 5'h1C;

    // Control field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_MODE_MSB = 3;
    localparam int CTRL_DIM_LSB = 4;
    localparam int CTRL_DIM_MSB = 5;
    localparam int CTRL_OSEL_BIT = 6;
    localparam int CTRL_WIDTH = 7;

    // Status and mask layout
    localparam int STAT_DONE_BIT = 0;

    // Transfer mode encodings
    localparam logic [2:0] MODE_PERIPH = 3'h5;
    localparam int MODE_KEEP_BIT = 2;

    // Address dimension encodings
    localparam logic [1:0] DIM_LINEAR = 2'h0;
    localparam logic [1:0] DIM_2D = 2'h1;
    localparam logic [1:0] DIM_3D = 2'h2;

    // Widths and reset values
    localparam int CNT_WIDTH = 24;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [31:0] ADDR_STEP = 32'h0000_0001;
    localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 24'h00_0000;
    localparam logic [CNT_WIDTH-1:0] CNT_ONE = 24'h00_0001;

    // Transfer engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } eng_state_e;

endpackage

// file: rtl/dma_channel_block_control.sv
// How it works
// - With the top mode bit at zero the channel clears its own enable when the block ends and stops.
// - With the top mode bit at one the enable stays set at block end so software may reload and restart.
// - Mode 101 serves a fixed peripheral data register per request and keeps the enable at block end.
// - A counter preset of N minus one gives exactly N word transfers in the block.
// - Block end sets a sticky done status bit that software can poll or take as an interrupt.
// - In 2D and 3D address modes the selected offset register is added to the addresses at block end, to the destination only in mode 101.
`timescale 1ns/1ns
module dma_channel_block_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic periph_req_i,
    output logic mem_cyc_o,
    output logic mem_we_o,
    output logic [31:0] mem_adr_o,
    output logic [31:0] mem_dat_o,
    input wire logic [31:0] mem_dat_i,
    input wire logic mem_ack_i,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [dma_channel_pkg::CTRL_WIDTH-1:0] ctrl_q;
    logic [31:0] src_q;
    logic [31:0] dst_q;
    logic [dma_channel_pkg::CNT_WIDTH-1:0] preset_q;
    logic [dma_channel_pkg::CNT_WIDTH-1:0] cnt_q;
    logic [31:0] ofs0_q;
    logic [31:0] ofs1_q;
    logic status_q;
    logic mask_q;
    dma_channel_pkg::eng_state_e state_q;

    logic bus_req;
    logic wr_stb;
    logic rd_stb;
    logic [31:0] lane_mask;
    logic [2:0] mode;
    logic [1:0] dim;
    logic keep_en;
    logic word_done;
    logic block_end;
    logic en_rise;
    logic [31:0] ctrl_word;
    logic [31:0] sel_ofs;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode helpers

    // One access per request, ack drops the cycle after
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_stb = bus_req & wb_we_i;
    assign rd_stb = bus_req & ~wb_we_i;

    // Byte lane write mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign lane_mask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    assign ctrl_word = {{(32 - dma_channel_pkg::CTRL_WIDTH){1'b0}}, ctrl_q};
    assign mode = ctrl_q[dma_channel_pkg::CTRL_MODE_MSB:dma_channel_pkg::CTRL_MODE_LSB];
    assign dim = ctrl_q[dma_channel_pkg::CTRL_DIM_MSB:dma_channel_pkg::CTRL_DIM_LSB];
    assign keep_en = mode[dma_channel_pkg::MODE_KEEP_BIT];
    assign sel_ofs = ctrl_q[dma_channel_pkg::CTRL_OSEL_BIT] ? ofs1_q : ofs0_q;

    // Word and block completion
    assign word_done = (state_q == dma_channel_pkg::ST_WRITE) & mem_ack_i;
    assign block_end = word_done & (cnt_q == dma_channel_pkg::CNT_ZERO);
    assign en_rise = wr_stb & (wb_adr_i == dma_channel_pkg::CTRL_OFS) & wb_sel_i[0]
                     & wb_dat_i[dma_channel_pkg::CTRL_EN_BIT] & ~ctrl_q[dma_channel_pkg::CTRL_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave answer

    // Ack one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Read data, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= dma_channel_pkg::ZERO_WORD;
        end else if (rd_stb) begin
            if (wb_adr_i == dma_channel_pkg::CTRL_OFS) begin
                wb_dat_o <= ctrl_word;
            end else if (wb_adr_i == dma_channel_pkg::SRC_OFS) begin
                wb_dat_o <= src_q;
            end else if (wb_adr_i == dma_channel_pkg::DST_OFS) begin
                wb_dat_o <= dst_q;
            end else if (wb_adr_i == dma_channel_pkg::COUNT_OFS) begin
                wb_dat_o <= {8'h00, cnt_q};
            end else if (wb_adr_i == dma_channel_pkg::OFFSET0_OFS) begin
                wb_dat_o <= ofs0_q;
            end else if (wb_adr_i == dma_channel_pkg::OFFSET1_OFS) begin
                wb_dat_o <= ofs1_q;
            end else if (wb_adr_i == dma_channel_pkg::STATUS_OFS) begin
                wb_dat_o <= {31'h0000_0000, status_q};
            end else if (wb_adr_i == dma_channel_pkg::MASK_OFS) begin
                wb_dat_o <= {31'h0000_0000, mask_q};
            end else begin
                wb_dat_o <= dma_channel_pkg::ZERO_WORD;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register and channel enable

    // Software write wins over the self clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= '0;
        end else if (wr_stb && wb_adr_i == dma_channel_pkg::CTRL_OFS) begin
            ctrl_q <= dma_channel_pkg::CTRL_WIDTH'(merge(ctrl_word, wb_dat_i, lane_mask));
        end else if (block_end && !keep_en) begin
            ctrl_q[dma_channel_pkg::CTRL_EN_BIT] <= 1'b0;
        end
        // Top mode bit set: enable left alone at block end
    end

    // Offset registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ofs0_q <= dma_channel_pkg::ZERO_WORD;
            ofs1_q <= dma_channel_pkg::ZERO_WORD;
        end else if (wr_stb && wb_adr_i == dma_channel_pkg::OFFSET0_OFS) begin
            ofs0_q <= merge(ofs0_q, wb_dat_i, lane_mask);
        end else if (wr_stb && wb_adr_i == dma_channel_pkg::OFFSET1_OFS) begin
            ofs1_q <= merge(ofs1_q, wb_dat_i, lane_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word counter

    // Preset holds N minus one, working count reloads per block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            preset_q <= dma_channel_pkg::CNT_ZERO;
            cnt_q <= dma_channel_pkg::CNT_ZERO;
        end else if (wr_stb && wb_adr_i == dma_channel_pkg::COUNT_OFS) begin
            preset_q <= dma_channel_pkg::CNT_WIDTH'(merge({8'h00, preset_q}, wb_dat_i, lane_mask));
            cnt_q <= dma_channel_pkg::CNT_WIDTH'(merge({8'h00, preset_q}, wb_dat_i, lane_mask));
        end else if (en_rise || block_end) begin
            cnt_q <= preset_q;
        end else if (word_done) begin
            cnt_q <= cnt_q - dma_channel_pkg::CNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address generation

    // Linear step per word, offset at block end in 2D or 3D
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_q <= dma_channel_pkg::ZERO_WORD;
            dst_q <= dma_channel_pkg::ZERO_WORD;
        end else if (wr_stb && wb_adr_i == dma_channel_pkg::SRC_OFS) begin
            src_q <= merge(src_q, wb_dat_i, lane_mask);
        end else if (wr_stb && wb_adr_i == dma_channel_pkg::DST_OFS) begin
            dst_q <= merge(dst_q, wb_dat_i, lane_mask);
        end else if (block_end && (dim == dma_channel_pkg::DIM_2D || dim == dma_channel_pkg::DIM_3D)) begin
            if (mode != dma_channel_pkg::MODE_PERIPH) begin
                src_q <= src_q + sel_ofs;
            end
            dst_q <= dst_q + sel_ofs;
        end else if (word_done) begin
            if (mode != dma_channel_pkg::MODE_PERIPH) begin
                src_q <= src_q + dma_channel_pkg::ADDR_STEP;
            end
            // Destination steps in every mode, only the source is held in mode 101
            dst_q <= dst_q + dma_channel_pkg::ADDR_STEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer engine

    // Read then write each word, start checked only when idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= dma_channel_pkg::ST_IDLE;
            mem_cyc_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_adr_o <= dma_channel_pkg::ZERO_WORD;
            mem_dat_o <= dma_channel_pkg::ZERO_WORD;
        end else begin
            case (state_q)
                dma_channel_pkg::ST_IDLE: begin
                    // Request driven words in the keep-enable modes
                    if (ctrl_q[dma_channel_pkg::CTRL_EN_BIT] && (!keep_en || periph_req_i)) begin
                        state_q <= dma_channel_pkg::ST_READ;
                        mem_cyc_o <= 1'b1;
                        mem_we_o <= 1'b0;
                        mem_adr_o <= src_q;
                    end
                end
                dma_channel_pkg::ST_READ: begin
                    if (mem_ack_i) begin
                        state_q <= dma_channel_pkg::ST_WRITE;
                        mem_we_o <= 1'b1;
                        mem_adr_o <= dst_q;
                        mem_dat_o <= mem_dat_i;
                    end
                end
                dma_channel_pkg::ST_WRITE: begin
                    // Enable clears at this edge, idle sees it cleared
                    if (mem_ack_i) begin
                        state_q <= dma_channel_pkg::ST_IDLE;
                        mem_cyc_o <= 1'b0;
                        mem_we_o <= 1'b0;
                    end
                end
                default: begin
                    state_q <= dma_channel_pkg::ST_IDLE;
                    mem_cyc_o <= 1'b0;
                    mem_we_o <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status, mask and interrupt

    // Sticky done, read clears, a new block end wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= 1'b0;
        end else if (block_end) begin
            status_q <= 1'b1;
        end else if (rd_stb && wb_adr_i == dma_channel_pkg::STATUS_OFS) begin
            status_q <= 1'b0;
        end
    end

    // Mask register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= 1'b0;
        end else if (wr_stb && wb_adr_i == dma_channel_pkg::MASK_OFS && wb_sel_i[0]) begin
            mask_q <= wb_dat_i[dma_channel_pkg::STAT_DONE_BIT];
        end
    end

    // Level interrupt from the next status value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= mask_q & (block_end | (status_q
                     & ~(rd_stb && wb_adr_i == dma_channel_pkg::STATUS_OFS)));
        end
    end

endmodule // dma_channel_block_control

// file: tb/dma_mem_model.sv
`timescale 1ns/1ns
module dma_mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic we_i,
    input wire logic stall_i,
    input wire logic [31:0] adr_i,
    output logic [31:0] dat_o,
    output logic ack_o
);
    logic [31:0] junk_q;

    // One-cycle ack per phase, after random stall cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            junk_q <= 32'h5a3c_96e1;
        end else begin
            ack_o <= cyc_i && !ack_o && !stall_i;
            junk_q <= {junk_q[30:0], ~junk_q[31]} ^ adr_i;
        end
    end

    // Read data only with ack, churn otherwise
    assign dat_o = (ack_o && !we_i) ? {~adr_i[15:0], adr_i[15:0]} : junk_q;
endmodule // dma_mem_model

// file: tb/dma_channel_block_control_chk.sv
`timescale 1ns/1ns
module dma_channel_block_control_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic mem_cyc_o,
    input wire logic mem_we_o,
    input wire logic [31:0] mem_adr_o,
    input wire logic [31:0] mem_dat_o,
    input wire logic [31:0] mem_dat_i,
    input wire logic mem_ack_i,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////
    property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_mem_hold; mem_cyc_o && !mem_ack_i |=> mem_cyc_o && $stable(mem_we_o) && $stable(mem_adr_o); endproperty
    property p_wr_data; mem_cyc_o && mem_we_o && !mem_ack_i |=> $stable(mem_dat_o); endproperty
    property p_rd_to_wr;
        mem_cyc_o && !mem_we_o && mem_ack_i |=> mem_cyc_o && mem_we_o && mem_dat_o == $past(mem_dat_i);
    endproperty
    property p_gap; mem_cyc_o && mem_we_o && mem_ack_i |=> !mem_cyc_o; endproperty
    property p_irq_rise;
        $rose(irq_o) |-> $past(mem_ack_i) || $past(mem_ack_i, 2) || $past(wb_stb_i) || $past(wb_stb_i, 2);
    endproperty
    property p_irq_fall; $fell(irq_o) |-> $past(wb_stb_i) || $past(wb_stb_i, 2) || $past(wb_stb_i, 3); endproperty

    a_ack_lat: assert property (p_ack_lat) else $error("bus ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack too long");
    a_mem_hold: assert property (p_mem_hold) else $error("memory request moved");
    a_wr_data: assert property (p_wr_data) else $error("write data moved");
    a_rd_to_wr: assert property (p_rd_to_wr) else $error("bad write phase");
    a_gap: assert property (p_gap) else $error("no idle after word");
    a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");

    c_irq: cover property ($rose(irq_o));
    c_stall: cover property ((mem_cyc_o && !mem_ack_i) [*3]);
    c_word: cover property (mem_cyc_o && mem_we_o && mem_ack_i);
endmodule // dma_channel_block_control_chk

bind dma_channel_block_control dma_channel_block_control_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_cyc_o(mem_cyc_o), .mem_we_o(mem_we_o),
    .mem_adr_o(mem_adr_o), .mem_dat_o(mem_dat_o), .mem_dat_i(mem_dat_i), .mem_ack_i(mem_ack_i), .irq_o(irq_o));

// file: tb/dma_channel_block_control_tb_top.sv
`timescale 1ns/1ns
module dma_channel_block_control_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, periph_req_i = 1'b0, stall = 1'b1, cyc_prev = 1'b0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, mem_adr_o, mem_dat_o, mem_dat_i;
    logic wb_ack_o, mem_cyc_o, mem_we_o, mem_ack_i, irq_o;
    logic [63:0] exp_q[$];
    logic [63:0] w;
    int fails = 0, cmp_count = 0, permits = 0;
    int seed = 32'haf7f_4394;

    always #4 clk_i = ~clk_i;

    dma_channel_block_control i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .periph_req_i(periph_req_i), .mem_cyc_o(mem_cyc_o), .mem_we_o(mem_we_o),
        .mem_adr_o(mem_adr_o), .mem_dat_o(mem_dat_o), .mem_dat_i(mem_dat_i), .mem_ack_i(mem_ack_i), .irq_o(irq_o));
    dma_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(mem_cyc_o), .we_i(mem_we_o), .stall_i(stall),
        .adr_i(mem_adr_o), .dat_o(mem_dat_i), .ack_o(mem_ack_i));

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // Wait for the answer however long it takes, the watchdog ends a hang
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask

    ////////////////////////////////////////////////////////////////
    // Random stalls and one peripheral request per word
    always @(posedge clk_i) begin
        stall <= $random(seed) & 1;
        cyc_prev <= mem_cyc_o;
        if (mem_cyc_o && !cyc_prev) permits <= permits - 1;
        periph_req_i <= permits > 0 && !mem_cyc_o;
    end

    // Every written word must be the next expected one
    always @(posedge clk_i) begin
        if (mem_cyc_o === 1'b1 && mem_we_o === 1'b1 && mem_ack_i === 1'b1) begin
            chk(32'(exp_q.size() != 0), 32'h0000_0001);
            if (exp_q.size() != 0) begin
                w = exp_q.pop_front();
                chk(mem_adr_o, w[63:32]);
                chk(mem_dat_o, w[31:0]);
            end
        end
    end

    // One run per mode, two blocks in the keep-enable modes, modelled word by word
    task automatic run(input logic [2:0] m);
        logic [31:0] s, d, o0, o1, off;
        logic [1:0] dm;
        logic os;
        int n, nb;
        s = $random(seed);
        d = $random(seed);
        o0 = $random(seed);
        o1 = $random(seed);
        os = $random(seed);
        dm = 2'(m % 3);
        n = 2 + ($random(seed) & 3);
        nb = m[2] ? 2 : 1;
        off = os ? o1 : o0;
        wr(dma_channel_pkg::SRC_OFS, s);
        wr(dma_channel_pkg::DST_OFS, d);
        wr(dma_channel_pkg::COUNT_OFS, 32'(n - 1));
        wr(dma_channel_pkg::OFFSET0_OFS, o0);
        wr(dma_channel_pkg::OFFSET1_OFS, o1);
        wr(dma_channel_pkg::MASK_OFS, 32'h0000_0001);
        for (int b = 0; b < nb; b++) begin
            for (int i = 0; i < n; i++) begin
                exp_q.push_back({d, {~s[15:0], s[15:0]}});
                if (i == n - 1 && dm != 2'h0) begin
                    s += (m == 3'h5) ? 0 : off;
                    d += off;
                end else begin
                    s += (m == 3'h5) ? 0 : 1;
                    d += 1;
                end
            end
        end
        permits = n * nb;
        wr(dma_channel_pkg::CTRL_OFS, 32'({os, dm, m, 1'b1}));
        for (int b = 0; b < nb; b++) begin
            for (int t = 0; t < 400 && irq_o !== 1'b1; t++) @(posedge clk_i);
            rd(dma_channel_pkg::STATUS_OFS, 32'h0000_0001);
            for (int t = 0; t < 8 && irq_o !== 1'b0; t++) @(posedge clk_i);
        end
        for (int t = 0; t < 400 && exp_q.size() != 0; t++) @(posedge clk_i);
        repeat (16) @(posedge clk_i);
        chk(32'(exp_q.size()), 32'h0000_0000);
        chk(32'(irq_o), 32'h0000_0000);
        rd(dma_channel_pkg::STATUS_OFS, 32'h0000_0000);
        rd(dma_channel_pkg::CTRL_OFS, 32'({os, dm, m, m[2]}));
        rd(dma_channel_pkg::SRC_OFS, s);
        rd(dma_channel_pkg::DST_OFS, d);
        wr(dma_channel_pkg::CTRL_OFS, 32'h0000_0000);
    endtask

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reset values, unmapped read, then every transfer mode
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 32; a += 4) rd(5'(a), 32'h0000_0000);
        rd(5'h02, 32'h0000_0000);
        wr(dma_channel_pkg::COUNT_OFS, 32'hffff_ffff);
        rd(dma_channel_pkg::COUNT_OFS, 32'h00ff_ffff);
        for (int m = 0; m < 8; m++) run(3'(m));
        complete_run;
    end

    // Watchdog against a hung run
    initial begin
        repeat (30000) @(posedge clk_i);
        fails++;
        complete_run;
    end
endmodule // dma_channel_block_control_tb_top
